// file: design/pgs_supervisor.sv
// power good and fault supervisor with its register slave
`timescale 1ns/1ps
`default_nettype none
module pgs_supervisor #(
  parameter logic [pgs_pkg::CNT_W-1:0] SS_CYCLES = pgs_pkg::SS_CYC,
  parameter logic [pgs_pkg::CNT_W-1:0] HICCUP_CYCLES = pgs_pkg::HICCUP_CYC,
  parameter logic [pgs_pkg::CNT_W-1:0] UV_QUAL_CYCLES = pgs_pkg::UV_QUAL_CYC,
  parameter logic [pgs_pkg::CNT_W-1:0] OV_QUAL_CYCLES = pgs_pkg::OV_QUAL_CYC,
  parameter logic [pgs_pkg::CNT_W-1:0] REL_CYCLES = pgs_pkg::REL_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [pgs_pkg::AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [pgs_pkg::AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // chip enable and supply comparators
  input wire logic chip_enable,
  input wire logic supply_low_lockout,
  input wire logic supply_high_lockout,
  input wire logic thermal_shutdown,
  // feedback comparators
  input wire logic fb_below_uv,
  input wire logic fb_above_uv_release,
  input wire logic fb_above_ov,
  input wire logic fb_below_ov_release,
  // mode pin and synchronisation
  input wire logic mode_pin_high,
  input wire logic mode_pin_low,
  input wire logic ext_clock_present,
  input wire logic max_duty,
  // switching cycle and switch-node sensing
  input wire logic cycle_start,
  input wire logic hs_on,
  input wire logic ls_on,
  input wire logic hs_vds_over,
  input wire logic ls_vds_over,
  input wire logic current_limit,
  // switching control outputs
  output logic switch_enable,
  output logic hs_gate_allow,
  output logic ls_gate_allow,
  output logic forced_pwm,
  output logic sync_active,
  output logic freq_quarter,
  output logic sync_clock_output_locked,
  // open-drain power good pin
  input wire logic power_good_out_in,
  output logic power_good_out_o,
  output logic power_good_out_oe
);
  import pgs_pkg::*;

  typedef struct packed {
    pgs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic [CNT_W-1:0] uv_rel;
    logic [CNT_W-1:0] ov_cnt;
    logic [CNT_W-1:0] ov_rel;
    logic uv_flag;
    logic uv_wait;
    logic ov_flag;
    logic ov_wait;
    logic hs_kill;
    logic ls_kill;
    logic fpwm_pin;
    logic fpwm;
    logic sync_on;
    logic quarter;
    logic pg_low;
    logic latch_mode;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] wd;
    logic wstrb0;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } pgs_regs_t;

  pgs_regs_t r;
  pgs_regs_t next_r;
  logic lockout;
  logic hs_cut;
  logic ls_cut;
  logic fault_trig;

  // word select of a byte address
  function automatic logic is_reg(input logic [AXI_AW-1:0] a,
                                  input logic [AXI_AW-1:0] ofs);
    is_reg = (a[AXI_AW-1:2] == ofs[AXI_AW-1:2]);
  endfunction

  assign lockout = supply_low_lockout | supply_high_lockout |
                   thermal_shutdown;
  assign hs_cut = r.hs_kill | (hs_on & hs_vds_over);
  assign ls_cut = r.ls_kill | (ls_on & ls_vds_over);
  assign fault_trig = r.uv_flag &
    (current_limit | (ls_on & ls_vds_over) | r.ov_flag);

  always_comb begin
    next_r = r;
    // undervoltage qualification and release
    if (!r.uv_flag) begin
      if (fb_below_uv) begin
        if (r.uv_cnt == UV_QUAL_CYCLES) begin
          next_r.uv_flag = 1'b1;
          next_r.uv_wait = 1'b0;
          next_r.uv_cnt = '0;
        end else begin
          next_r.uv_cnt = r.uv_cnt + 1'b1;
        end
      end else begin
        next_r.uv_cnt = '0;
      end
    end else if (fb_above_uv_release) begin
      next_r.uv_flag = 1'b0;
      next_r.uv_wait = 1'b1;
      next_r.uv_rel = '0;
    end
    if (r.uv_wait && !r.uv_flag) begin
      if (!fb_above_uv_release) begin
        next_r.uv_rel = '0;
      end else if (r.uv_rel == REL_CYCLES) begin
        next_r.uv_wait = 1'b0;
      end else begin
        next_r.uv_rel = r.uv_rel + 1'b1;
      end
    end
    // overvoltage qualification and release
    if (!r.ov_flag) begin
      if (fb_above_ov) begin
        if (r.ov_cnt == OV_QUAL_CYCLES) begin
          next_r.ov_flag = 1'b1;
          next_r.ov_wait = 1'b0;
          next_r.ov_cnt = '0;
        end else begin
          next_r.ov_cnt = r.ov_cnt + 1'b1;
        end
      end else begin
        next_r.ov_cnt = '0;
      end
    end else if (fb_below_ov_release) begin
      next_r.ov_flag = 1'b0;
      next_r.ov_wait = 1'b1;
      next_r.ov_rel = '0;
    end
    if (r.ov_wait && !r.ov_flag) begin
      if (!fb_below_ov_release) begin
        next_r.ov_rel = '0;
      end else if (r.ov_rel == REL_CYCLES) begin
        next_r.ov_wait = 1'b0;
      end else begin
        next_r.ov_rel = r.ov_rel + 1'b1;
      end
    end
    // operating state
    unique case (r.st)
      SUP_SHUT, SUP_LOCK: begin
        if (lockout) begin
          next_r.st = SUP_LOCK;
        end else begin
          next_r.st = SUP_SOFT;
          next_r.cnt = '0;
        end
      end
      SUP_SOFT, SUP_RUN: begin
        if (lockout) begin
          next_r.st = SUP_LOCK;
        end else if (fault_trig) begin
          next_r.st = SUP_PROT;
          next_r.cnt = '0;
        end else if (r.st == SUP_SOFT) begin
          if (r.cnt == SS_CYCLES) begin
            next_r.st = SUP_RUN;
          end else begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end
      end
      SUP_PROT: begin
        if (supply_low_lockout) begin
          next_r.st = SUP_LOCK;
        end else if (!r.latch_mode) begin
          if (r.cnt == HICCUP_CYCLES) begin
            next_r.st = SUP_SOFT;
            next_r.cnt = '0;
          end else begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end
      end
      default: begin
        next_r.st = SUP_SHUT;
      end
    endcase
    // per-cycle switch-node short kill
    if (cycle_start) begin
      next_r.hs_kill = 1'b0;
      next_r.ls_kill = 1'b0;
    end else begin
      next_r.hs_kill = hs_cut;
      next_r.ls_kill = ls_cut;
    end
    // mode selection and synchronisation
    if (mode_pin_high) begin
      next_r.fpwm_pin = 1'b1;
    end else if (mode_pin_low) begin
      next_r.fpwm_pin = 1'b0;
    end
    next_r.fpwm = next_r.fpwm_pin | ext_clock_present;
    next_r.sync_on = ext_clock_present & ~max_duty;
    next_r.quarter = ext_clock_present & max_duty;
    // shutdown clears supervisor state
    if (!chip_enable) begin
      next_r.st = SUP_SHUT;
      next_r.cnt = '0;
      next_r.uv_cnt = '0;
      next_r.uv_rel = '0;
      next_r.ov_cnt = '0;
      next_r.ov_rel = '0;
      next_r.uv_flag = 1'b0;
      next_r.uv_wait = 1'b0;
      next_r.ov_flag = 1'b0;
      next_r.ov_wait = 1'b0;
      next_r.hs_kill = 1'b0;
      next_r.ls_kill = 1'b0;
    end
    // power good pull-down
    next_r.pg_low = !chip_enable || lockout || (next_r.st != SUP_RUN) ||
      next_r.uv_flag || next_r.uv_wait ||
      next_r.ov_flag || next_r.ov_wait;
    // axi4-lite write
    if (awvalid && !r.aw_got && !r.bv) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && !r.w_got && !r.bv) begin
      next_r.w_got = 1'b1;
      next_r.wd = wdata;
      next_r.wstrb0 = wstrb[0];
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bv = 1'b1;
      if (is_reg(r.aw_addr, CTRL_OFS)) begin
        next_r.br = RESP_OKAY;
        if (r.wstrb0) begin
          next_r.latch_mode = r.wd[CTRL_LATCH_BIT];
        end
      end else if (is_reg(r.aw_addr, STATUS_OFS)) begin
        next_r.br = RESP_OKAY;
      end else begin
        next_r.br = RESP_SLVERR;
      end
    end
    if (r.bv && bready) begin
      next_r.bv = 1'b0;
    end
    // axi4-lite read
    if (r.rv && rready) begin
      next_r.rv = 1'b0;
    end
    if (arvalid && !r.rv) begin
      next_r.rv = 1'b1;
      next_r.rd = '0;
      next_r.rr = RESP_OKAY;
      if (is_reg(araddr, CTRL_OFS)) begin
        next_r.rd[CTRL_LATCH_BIT] = r.latch_mode;
      end else if (is_reg(araddr, STATUS_OFS)) begin
        next_r.rd[ST_PG_LOW_BIT] = r.pg_low;
        next_r.rd[ST_UV_BIT] = r.uv_flag;
        next_r.rd[ST_OV_BIT] = r.ov_flag;
        next_r.rd[ST_LOCK_BIT] = lockout;
        next_r.rd[ST_FPWM_BIT] = r.fpwm;
        next_r.rd[ST_SYNC_BIT] = r.sync_on;
        next_r.rd[ST_QUART_BIT] = r.quarter;
        next_r.rd[ST_PIN_BIT] = power_good_out_in;
        next_r.rd[ST_STATE_LSB +: 5] = r.st;
      end else begin
        next_r.rr = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= SUP_SHUT;
      r.pg_low <= 1'b1;
      r.latch_mode <= CTRL_LATCH_RST;
    end else begin
      r <= next_r;
    end
  end

  assign awready = !r.aw_got && !r.bv;
  assign wready = !r.w_got && !r.bv;
  assign bvalid = r.bv;
  assign bresp = r.br;
  assign arready = !r.rv;
  assign rvalid = r.rv;
  assign rdata = r.rd;
  assign rresp = r.rr;
  assign switch_enable = (r.st == SUP_SOFT || r.st == SUP_RUN) &&
    !lockout && !r.ov_flag && !r.ov_wait && chip_enable;
  assign hs_gate_allow = switch_enable && !hs_cut;
  assign ls_gate_allow = switch_enable && !ls_cut;
  assign forced_pwm = r.fpwm;
  assign sync_active = r.sync_on;
  assign freq_quarter = r.quarter;
  assign sync_clock_output_locked = r.sync_on;
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe = r.pg_low;
endmodule
`default_nettype wire

// file: inc/pgs_pkg.sv
// package: constants and state type for the power good and fault supervisor
// Function
// - bias supply lockout halts switching; soft start on release.
// - input overvoltage lockout halts switching; soft start on release.
// - external sync clock on mode pin forces PWM mode.
// - soft start and clock synchronisation run together at start-up.
// - max duty: sync dropped, quarter external rate, clock output unlocked.
// - power good pulled low for enable, lockout, thermal, soft start, faults.
// - power good released once every pulling condition has cleared.
// - undervoltage flagged after feedback low longer than 30 us.
// - undervoltage clears above recovery level; power good after 120 us.
// - protection trips only on limit, low-side short or overvoltage during low output.
// - qualified feedback overvoltage stops switching.
// - overvoltage pulls power good low after feedback high longer than 30 us.
// - under overvoltage release, power good and switching return in 120 us.
// - low-side switch cut at once when its drain-source level is exceeded.
// - high-side switch cut at once when its drain-source level is exceeded.
// - short protection re-armed every switching cycle.
// - mode pin high selects forced PWM, low selects auto PWM/VFM.
// - hiccup restarts after 7 ms; latch holds until enable low or bias low.
`default_nettype none
package pgs_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CNT_W = 21;
  localparam int SS_TIME_US = 600;
  localparam int HICCUP_TIME_MS = 7;
  localparam int UV_QUAL_US = 30;
  localparam int OV_QUAL_US = 30;
  localparam int REL_DELAY_US = 120;
  localparam logic [CNT_W-1:0] SS_CYC = CNT_W'(SS_TIME_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] HICCUP_CYC =
    CNT_W'(HICCUP_TIME_MS * 1000 * CYC_PER_US);
  localparam logic [CNT_W-1:0] UV_QUAL_CYC = CNT_W'(UV_QUAL_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] OV_QUAL_CYC = CNT_W'(OV_QUAL_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] REL_CYC = CNT_W'(REL_DELAY_US * CYC_PER_US);
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h04;
  localparam int CTRL_LATCH_BIT = 0;
  localparam logic CTRL_LATCH_RST = 1'b0;
  localparam int ST_PG_LOW_BIT = 0;
  localparam int ST_UV_BIT = 1;
  localparam int ST_OV_BIT = 2;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_FPWM_BIT = 4;
  localparam int ST_SYNC_BIT = 5;
  localparam int ST_QUART_BIT = 6;
  localparam int ST_PIN_BIT = 7;
  localparam int ST_STATE_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    SUP_SHUT = 5'h01,
    SUP_LOCK = 5'h02,
    SUP_SOFT = 5'h04,
    SUP_RUN = 5'h08,
    SUP_PROT = 5'h10
  } pgs_state_t;
endpackage
`default_nettype wire

// file: tb/pgs_checker.sv
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module pgs_checker #(
  parameter logic [pgs_pkg::CNT_W-1:0] UV_QUAL_CYCLES = pgs_pkg::UV_QUAL_CYC,
  parameter logic [pgs_pkg::CNT_W-1:0] OV_QUAL_CYCLES = pgs_pkg::OV_QUAL_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // supervisor inputs
  input wire logic chip_enable,
  input wire logic supply_low_lockout,
  input wire logic supply_high_lockout,
  input wire logic fb_below_uv,
  input wire logic fb_above_ov,
  input wire logic ext_clock_present,
  input wire logic max_duty,
  input wire logic cycle_start,
  input wire logic hs_on,
  input wire logic ls_on,
  input wire logic hs_vds_over,
  input wire logic ls_vds_over,
  // supervisor outputs
  input wire logic switch_enable,
  input wire logic hs_gate_allow,
  input wire logic ls_gate_allow,
  input wire logic forced_pwm,
  input wire logic sync_active,
  input wire logic freq_quarter,
  input wire logic power_good_out_oe,
  input wire logic sync_clock_output_locked
);
  import pgs_pkg::*;
  logic [CNT_W-1:0] uv_cnt;
  logic [CNT_W-1:0] ov_cnt;
  // consecutive cycles of each feedback fault level
  always_ff @(posedge aclk) begin
    if (!aresetn || !chip_enable) begin
      uv_cnt <= '0;
      ov_cnt <= '0;
    end else begin
      uv_cnt <= fb_below_uv ? uv_cnt + 1'h1 : '0;
      ov_cnt <= fb_above_ov ? ov_cnt + 1'h1 : '0;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ls_short_cut: assert property (
    ls_on && ls_vds_over |-> !ls_gate_allow) else $error("low-side not cut");
  a_hs_short_cut: assert property (
    hs_on && hs_vds_over |-> !hs_gate_allow) else $error("high-side not cut");
  a_kill_hold: assert property (
    hs_on && hs_vds_over && !cycle_start |=> !hs_gate_allow)
    else $error("high-side kill not held");
  a_kill_rearm: assert property (
    cycle_start && !hs_vds_over ##1 switch_enable && !hs_vds_over
    |-> hs_gate_allow) else $error("high-side kill not re-armed");
  a_enable_off: assert property (
    !chip_enable |-> !switch_enable ##1 power_good_out_oe)
    else $error("enable low not shut down");
  a_lockout_stop: assert property (
    supply_low_lockout || supply_high_lockout
    |=> !switch_enable && power_good_out_oe) else $error("lockout ignored");
  a_uv_qual: assert property (
    uv_cnt > UV_QUAL_CYCLES + 2 |-> power_good_out_oe)
    else $error("undervoltage not flagged");
  a_ov_stop: assert property (
    ov_cnt > OV_QUAL_CYCLES + 2 |-> power_good_out_oe && !switch_enable)
    else $error("overvoltage not acted on");
  a_sync_pwm: assert property (
    ext_clock_present && !max_duty && switch_enable
    |=> sync_active && forced_pwm) else $error("sync without forced pwm");
  a_quarter_freq: assert property (
    ext_clock_present && max_duty && switch_enable
    |=> freq_quarter && !sync_active) else $error("max duty kept sync");
  a_sync_clock_output_drop: assert property (
    ext_clock_present && max_duty && switch_enable
    |=> !sync_clock_output_locked) else $error("clock output kept sync");
endmodule
bind pgs_supervisor pgs_checker #(
  .UV_QUAL_CYCLES(UV_QUAL_CYCLES),
  .OV_QUAL_CYCLES(OV_QUAL_CYCLES)
) pgs_checker_i (
  .aclk, .aresetn, .chip_enable, .supply_low_lockout, .supply_high_lockout,
  .fb_below_uv, .fb_above_ov, .ext_clock_present, .max_duty, .cycle_start,
  .hs_on, .ls_on, .hs_vds_over, .ls_vds_over, .switch_enable,
  .hs_gate_allow, .ls_gate_allow, .forced_pwm, .sync_active, .freq_quarter,
  .power_good_out_oe, .sync_clock_output_locked
);
`default_nettype wire

// file: tb/pgs_pg_monitor.sv
// power good pull-up and external clock source model
`timescale 1ns/1ps
`default_nettype none
module pgs_pg_monitor (
  // open-drain pin from the supervisor
  input wire logic pg_oe,
  input wire logic pg_o,
  // clock source request from the bench
  input wire logic clk_req,
  // pin level and clock presence
  output logic pg_pin,
  output logic ext_clock_present
);
  // pull-up wins while the pin is released
  assign pg_pin = pg_oe ? pg_o : 1'h1;
  // source keeps pulses wide enough and the rate in range
  assign ext_clock_present = clk_req;
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pgs_pkg::*;
  localparam logic [33:0] MS = 34'h300001F8F;
  localparam logic [33:0] MF = 34'h3FFFFFFFF;
  localparam logic [19:0] MODES = 20'h80423;
  localparam logic [39:0] MEXP = 40'h1010003040;
  localparam logic [39:0] MMSK = 40'h7070707060;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic chip_enable = 1'h0, supply_low_lockout = 1'h0;
  logic supply_high_lockout = 1'h0, thermal_shutdown = 1'h0;
  logic fb_below_uv = 1'h0, fb_above_uv_release = 1'h1;
  logic fb_above_ov = 1'h0, fb_below_ov_release = 1'h1;
  logic mode_pin_high = 1'h0, mode_pin_low = 1'h1, max_duty = 1'h0;
  logic clk_req = 1'h1, ext_clock_present, current_limit = 1'h0;
  logic cycle_start = 1'h0, hs_on = 1'h0, ls_on = 1'h0;
  logic hs_vds_over = 1'h0, ls_vds_over = 1'h0;
  logic switch_enable, hs_gate_allow, ls_gate_allow, forced_pwm;
  logic sync_active, freq_quarter, sync_clock_output_locked;
  logic power_good_out_in, power_good_out_o, power_good_out_oe;
  logic [33:0] eq[$], mq[$];
  logic [1:0] bq[$];
  int n_fail = 0, compares = 0, cycles = 0, i;
  pgs_supervisor #(.SS_CYCLES(21'h14), .HICCUP_CYCLES(21'h1E),
    .UV_QUAL_CYCLES(21'h5), .OV_QUAL_CYCLES(21'h5), .REL_CYCLES(21'hA)
  ) pgs_supervisor_i (.*);
  pgs_pg_monitor pgs_pg_monitor_i (.pg_oe(power_good_out_oe),
    .pg_o(power_good_out_o), .clk_req(clk_req), .pg_pin(power_good_out_in),
    .ext_clock_present(ext_clock_present));
  always #2.5 aclk = ~aclk;
  task final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [33:0] g, input logic [33:0] e, input logic [33:0] m);
    compares++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g & m, e & m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask
  // result watcher: oldest note against each answer
  always @(posedge aclk) begin
    cycles++;
    if (rvalid && rready) cmp({rresp, rdata}, eq.pop_front(), mq.pop_front());
    if (bvalid && bready) cmp({32'h0, bresp}, {32'h0, bq.pop_front()}, MF);
    if (cycles == 5000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    void'($urandom(9));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL_OFS, 34'h0, MF);
    rd(STATUS_OFS, 34'h101, MS);
    rd(8'h08, 34'h200000000, MF);
    wr(STATUS_OFS, $urandom(), RESP_OKAY);
    wr(8'h0C, $urandom(), RESP_SLVERR);
    $display("test registers done");
    chip_enable <= 1'h1;
    cyc(5);
    rd(STATUS_OFS, 34'h431, MS | 34'h30);
    clk_req <= 1'h0;
    cyc(30);
    rd(STATUS_OFS, 34'h880, MS);
    $display("test startup done");
    for (i = 0; i < 300; i++) begin
      @(posedge aclk);
      r = $urandom();
      {current_limit, ls_vds_over, hs_vds_over, hs_on} <= r[3:0];
      ls_on <= ~r[0];
      cycle_start <= (i % 8 == 0);
    end
    @(posedge aclk);
    {current_limit, ls_vds_over, hs_vds_over, hs_on, ls_on} <= 5'h0;
    rd(STATUS_OFS, 34'h880, MS);
    $display("test switch node done");
    {fb_below_uv, fb_above_uv_release} <= 2'h2;
    cyc(5);
    {fb_below_uv, fb_above_uv_release} <= 2'h1;
    rd(STATUS_OFS, 34'h880, MS);
    {fb_below_uv, fb_above_uv_release} <= 2'h2;
    cyc(10);
    rd(STATUS_OFS, 34'h803, MS);
    {fb_below_uv, fb_above_uv_release} <= 2'h1;
    cyc(4);
    rd(STATUS_OFS, 34'h801, MS);
    cyc(20);
    rd(STATUS_OFS, 34'h880, MS);
    {fb_above_ov, fb_below_ov_release} <= 2'h2;
    cyc(10);
    rd(STATUS_OFS, 34'h805, MS);
    {fb_above_ov, fb_below_ov_release} <= 2'h1;
    cyc(3);
    rd(STATUS_OFS, 34'h801, MS);
    cyc(20);
    rd(STATUS_OFS, 34'h880, MS);
    $display("test feedback done");
    for (i = 0; i < 2; i++) begin
      wr(CTRL_OFS, $urandom() & 32'hFFFFFFFE | i, RESP_OKAY);
      {fb_below_uv, fb_above_uv_release} <= 2'h2;
      cyc(10);
      {current_limit, ls_on, ls_vds_over} <= i ? 3'h3 : 3'h4;
      cyc(1);
      {current_limit, ls_on, ls_vds_over} <= 3'h0;
      rd(STATUS_OFS, 34'h1003, MS);
      {fb_below_uv, fb_above_uv_release} <= 2'h1;
      cyc(70);
      rd(STATUS_OFS, i ? 34'h1001 : 34'h880, MS);
    end
    wstrb <= 4'hE;
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    rd(CTRL_OFS, 34'h1, 34'h300000001);
    $display("test protection done");
    for (i = 0; i < 3; i++) begin
      {thermal_shutdown, supply_high_lockout, supply_low_lockout} <= 3'h1 << i;
      cyc(3);
      rd(STATUS_OFS, 34'h209, MS);
      {thermal_shutdown, supply_high_lockout, supply_low_lockout} <= 3'h0;
      cyc(40);
      rd(STATUS_OFS, 34'h880, MS);
    end
    $display("test lockout done");
    for (i = 0; i < 5; i++) begin
      {mode_pin_high, mode_pin_low, clk_req, max_duty} <= MODES[16-4*i +: 4];
      cyc(3);
      rd(STATUS_OFS, {26'h0, MEXP[32-8*i +: 8]},
        {26'h3000000, MMSK[32-8*i +: 8]});
    end
    {mode_pin_high, mode_pin_low, clk_req, max_duty} <= 4'h4;
    $display("test mode done");
    chip_enable <= 1'h0;
    cyc(3);
    rd(STATUS_OFS, 34'h101, MS);
    $display("test disable done");
    final_report();
  end
endmodule
`default_nettype wire
